// ### rtl/npiu_regs.vh
// Purpose: register offsets, field positions, reset values for the interrupt unit
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: all offsets are local to the unit's APB window
`ifndef NPIU_REGS_VH
`define NPIU_REGS_VH
`define NPIU_OFF_STATUS 12'h000
`define NPIU_OFF_MONITOR 12'h004
`define NPIU_OFF_CTRL 12'h008
`define NPIU_OFF_MASK_LO 12'h00c
`define NPIU_OFF_MASK_HI 12'h010
`define NPIU_OFF_VECTOR 12'h014
`define NPIU_OFF_LEVEL_LO 12'h018
`define NPIU_OFF_LEVEL_HI 12'h01c
`define NPIU_OFF_DEBUG 12'h020
`define NPIU_OFF_CORE 12'h024
`define NPIU_OFF_ESP 12'h028
`define NPIU_OFF_PC 12'h02c
`define NPIU_OFF_PSW 12'h030
`define NPIU_OFF_BASE 12'h034
`define NPIU_OFF_CMD 12'h038
`define NPIU_BIT_ONESHOT 0
`define NPIU_BIT_PIN 1
`define NPIU_BIT_STICKY 2
`define NPIU_BIT_GLOBAL 0
`define NPIU_BIT_LOCAL 1
`define NPIU_BIT_CMD_TAKE 0
`define NPIU_BIT_CMD_RET 1
`define NPIU_BIT_CMD_EI 2
`define NPIU_BIT_CMD_DI 3
`define NPIU_MASK_RST 16'hffff
`define NPIU_STACK_STEP 21'h000004
`define NPIU_NMI_VEC 6'h01
`define NPIU_IRQ_VEC_BASE 6'h10
`endif

// ### rtl/npiu_pin_sync.v
// Purpose: two-flop synchroniser and falling-edge detector for the trap pin
// Assumes: pin is asynchronous to ref_clk
// Notes: first flop feeds only the second flop
`timescale 1ns/10ps
module npiu_pin_sync (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  // pin and results
  input wire pin_in,
  output reg level_o,
  output wire fall_o
);
  reg meta_r;
  reg sync_r;
  reg prev_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else if (clk_en) begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  always @* begin
    level_o = sync_r;
  end
  assign fall_o = prev_r & ~sync_r;
endmodule // npiu_pin_sync

// ### rtl/npiu_prio_enc.v
// Purpose: fixed-priority encoder over 32 request lines
// Assumes: line 31 highest, line 0 lowest
// Notes: purely combinational
`timescale 1ns/10ps
module npiu_prio_enc (
  // requests
  input wire [31:0] req_i,
  // result
  output reg hit_o,
  output reg [4:0] idx_o
);
  integer i;
  always @* begin
    hit_o = 1'b0;
    idx_o = 5'h00;
    for (i = 0; i < 32; i = i + 1) begin
      if (req_i[i]) begin
        hit_o = 1'b1;
        idx_o = i[4:0];
      end
    end
  end
endmodule // npiu_prio_enc

// ### rtl/npiu_top.v
// Purpose: urgent trap and 27-source maskable interrupt unit with core stack state
// Assumes: APB slave, one clock, async active-high reset
// Notes: stack memory writes are issued as strobes; the core performs them
//
// Function
// - entry pushes pc and status, pointer minus four
// - return restores pc and status, plus four
// - stack grows down, shrinks up
// - falling pin edge raises enabled trap
// - pin synchronised internally
// - trap disabled after reset
// - one-shot bit enables, trap clears it unless sticky set
// - sticky bit cleared only by reset
// - sticky enable allows nested traps
// - one-shot ignored while sticky set
// - 27 level maskable request inputs
// - highest pending enabled request served first
// - line 31 highest, line 0 lowest
// - peripheral enable and mask both required
// - global and local flags gate all
// - line 0 tied to no source
// - lines 31..27 timer sources
// - lines 26..23 versatile timer, 22..19 reserved
// - vector reports highest enabled pending
// - status cleared by reset and read
// - masks reset to all ones
// - control exposes read-only pin level
`timescale 1ns/10ps
`include "npiu_regs.vh"
module npiu_top (
  // clock, reset, enable
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // urgent trap pin, active low
  input wire trap_pin_n,
  // named sources
  input wire timer0_tick,
  input wire timer1_input_a,
  input wire timer1_input_b,
  input wire timer2_input_a,
  input wire timer2_input_b,
  input wire [3:0] versatile_timer_req,
  // remaining sources, lines 18..1, and peripheral enables for all 32 lines
  input wire [17:0] other_req,
  input wire [31:0] periph_en,
  // core side
  output reg irq_req_r,
  output reg [5:0] irq_vec_r,
  output reg trap_req_r,
  output reg push_stb_r,
  output reg pop_stb_r,
  output reg [20:0] stack_addr_r,
  output reg [20:0] dispatch_addr_r
);
  reg [15:0] request_mask_low;
  reg [15:0] request_mask_high;
  reg oneshot_r;
  reg sticky_trap_enable;
  reg urgent_request_status;
  reg urgent_request_monitor;
  reg [11:0] controller_debug_reg;
  reg [1:0] core_status_word;
  reg [20:0] exception_stack_pointer;
  reg [20:0] program_stack_pointer;
  reg [20:0] saved_pc_r;
  reg [1:0] saved_psw_r;
  reg [20:0] dispatch_table_base;
  reg [5:0] winner_vector_field;
  reg [31:0] req_sync1_r;
  reg [31:0] req_lvl_r;
  wire pin_level;
  wire pin_fall;
  wire win_hit;
  wire [4:0] win_idx;
  wire [31:0] raw_req;
  wire [31:0] eligible;
  wire wr_acc;
  wire rd_acc;
  wire trap_armed;
  wire take_irq;
  wire [20:0] tbl_addr;
  wire [20:0] esp_dec;
  wire [20:0] esp_inc;
  wire trap_event;
  wire wr_ctrl;
  wire wr_monitor;
  wire rd_status;
  wire rd_vector;
  wire [5:0] vec_now;

  // table entry address: base plus vector times two
  function [20:0] npiu_entry;
    input [20:0] base;
    input [5:0] vec;
    begin
      npiu_entry = base + {14'h0000, vec, 1'b0};
    end
  endfunction

  // address decode, shared by the write, clear-on-read and read paths
  function npiu_at;
    input [11:0] addr;
    input [11:0] off;
    begin
      npiu_at = (addr == off);
    end
  endfunction

  // vector code: base plus line number, zero when nothing is eligible
  function [5:0] npiu_vec;
    input hit;
    input [4:0] idx;
    begin
      npiu_vec = hit ? (`NPIU_IRQ_VEC_BASE + {1'b0, idx}) : 6'h00;
    end
  endfunction

  assign raw_req = {timer0_tick, timer1_input_a, timer1_input_b, timer2_input_a,
                    timer2_input_b, versatile_timer_req, 4'h0, other_req, 1'b0};

  npiu_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(trap_pin_n),
    .level_o(pin_level),
    .fall_o(pin_fall)
  );

  assign eligible = req_lvl_r & periph_en & {request_mask_high, request_mask_low};

  npiu_prio_enc u_enc (
    .req_i(eligible),
    .hit_o(win_hit),
    .idx_o(win_idx)
  );

  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_acc = psel & penable & ~pwrite & pready;
  assign trap_armed = sticky_trap_enable | oneshot_r;
  assign take_irq = win_hit & core_status_word[`NPIU_BIT_GLOBAL]
                    & core_status_word[`NPIU_BIT_LOCAL];
  assign tbl_addr = npiu_entry(dispatch_table_base, winner_vector_field);
  assign esp_dec = exception_stack_pointer - `NPIU_STACK_STEP;
  assign esp_inc = exception_stack_pointer + `NPIU_STACK_STEP;
  assign trap_event = pin_fall & trap_armed;
  assign wr_ctrl = wr_acc & npiu_at(paddr, `NPIU_OFF_CTRL);
  assign wr_monitor = wr_acc & npiu_at(paddr, `NPIU_OFF_MONITOR);
  assign rd_status = rd_acc & npiu_at(paddr, `NPIU_OFF_STATUS);
  assign rd_vector = rd_acc & npiu_at(paddr, `NPIU_OFF_VECTOR);
  // request flag and core vector come from the same cycle, so the core
  // never sees a new request paired with a stale vector
  assign vec_now = npiu_vec(win_hit, win_idx);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_sync1_r <= 32'h00000000;
      req_lvl_r <= 32'h00000000;
    end else if (clk_en) begin
      req_sync1_r <= raw_req;
      req_lvl_r <= req_sync1_r;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      winner_vector_field <= 6'h00;
    end else if (clk_en) begin
      winner_vector_field <= vec_now;
    end
  end

  // apb answers in the access cycle; one wait-free handshake
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
    end
  end

  // trap enables and status
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oneshot_r <= 1'b0;
      sticky_trap_enable <= 1'b0;
      urgent_request_status <= 1'b0;
      urgent_request_monitor <= 1'b0;
      trap_req_r <= 1'b0;
    end else if (clk_en) begin
      trap_req_r <= trap_event;
      // sticky set by write, cleared only by reset
      if (wr_ctrl && pwdata[`NPIU_BIT_STICKY]) begin
        sticky_trap_enable <= 1'b1;
      end
      // one-shot: trap clears it unless sticky is set, and then beats a write in the same cycle
      if (trap_event && !sticky_trap_enable) begin
        oneshot_r <= 1'b0;
      end else if (wr_ctrl) begin
        oneshot_r <= pwdata[`NPIU_BIT_ONESHOT];
      end
      // every armed edge recorded, nested allowed
      if (trap_event) begin
        urgent_request_status <= 1'b1;
      end else if (rd_status) begin
        urgent_request_status <= 1'b0;
      end
      // an edge in the clearing cycle is kept, so no trap goes unrecorded
      urgent_request_monitor <= urgent_request_monitor | trap_event;
      if (wr_monitor) begin
        urgent_request_monitor <= trap_event;
      end
    end
  end

  // masks, core flags, stack state
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      request_mask_low <= `NPIU_MASK_RST;
      request_mask_high <= `NPIU_MASK_RST;
      core_status_word <= 2'b00;
      exception_stack_pointer <= 21'h000000;
      program_stack_pointer <= 21'h000000;
      saved_pc_r <= 21'h000000;
      saved_psw_r <= 2'b00;
      dispatch_table_base <= 21'h000000;
      controller_debug_reg <= 12'h000;
      irq_req_r <= 1'b0;
      irq_vec_r <= 6'h00;
      push_stb_r <= 1'b0;
      pop_stb_r <= 1'b0;
      stack_addr_r <= 21'h000000;
      dispatch_addr_r <= 21'h000000;
    end else if (clk_en) begin
      push_stb_r <= 1'b0;
      pop_stb_r <= 1'b0;
      irq_req_r <= take_irq;
      irq_vec_r <= vec_now;
      if (take_irq) begin
        controller_debug_reg[11:6] <= vec_now;
      end
      if (rd_vector) begin
        controller_debug_reg[5:0] <= winner_vector_field;
      end
      if (wr_acc) begin
        case (paddr)
          `NPIU_OFF_MASK_LO: request_mask_low <= pwdata[15:0];
          `NPIU_OFF_MASK_HI: request_mask_high <= pwdata[15:0];
          `NPIU_OFF_CORE: core_status_word <= pwdata[1:0];
          `NPIU_OFF_ESP: exception_stack_pointer <= pwdata[20:0];
          `NPIU_OFF_PC: program_stack_pointer <= pwdata[20:0];
          `NPIU_OFF_PSW: saved_pc_r <= pwdata[20:0];
          `NPIU_OFF_BASE: dispatch_table_base <= {5'h00, pwdata[15:1], 1'b0};
          `NPIU_OFF_CMD: begin
            if (pwdata[`NPIU_BIT_CMD_EI]) begin
              core_status_word[`NPIU_BIT_LOCAL] <= 1'b1;
            end
            if (pwdata[`NPIU_BIT_CMD_DI]) begin
              core_status_word[`NPIU_BIT_LOCAL] <= 1'b0;
            end
            if (pwdata[`NPIU_BIT_CMD_TAKE]) begin
              exception_stack_pointer <= esp_dec;
              stack_addr_r <= esp_dec;
              saved_psw_r <= core_status_word;
              push_stb_r <= 1'b1;
              core_status_word[`NPIU_BIT_GLOBAL] <= 1'b0;
              dispatch_addr_r <= tbl_addr;
            end else if (pwdata[`NPIU_BIT_CMD_RET]) begin
              exception_stack_pointer <= esp_inc;
              stack_addr_r <= exception_stack_pointer;
              core_status_word <= saved_psw_r;
              pop_stb_r <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux and error on unmapped address
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `NPIU_OFF_STATUS: prdata <= {31'h00000000, urgent_request_status};
          `NPIU_OFF_MONITOR: prdata <= {31'h00000000, urgent_request_monitor};
          `NPIU_OFF_CTRL: prdata <= {29'h00000000, sticky_trap_enable, pin_level, oneshot_r};
          `NPIU_OFF_MASK_LO: prdata <= {16'h0000, request_mask_low};
          `NPIU_OFF_MASK_HI: prdata <= {16'h0000, request_mask_high};
          `NPIU_OFF_VECTOR: prdata <= {26'h0000000, winner_vector_field};
          `NPIU_OFF_LEVEL_LO: prdata <= {16'h0000, req_lvl_r[15:0]};
          `NPIU_OFF_LEVEL_HI: prdata <= {16'h0000, req_lvl_r[31:16]};
          `NPIU_OFF_DEBUG: prdata <= {20'h00000, controller_debug_reg};
          `NPIU_OFF_CORE: prdata <= {30'h00000000, core_status_word};
          `NPIU_OFF_ESP: prdata <= {11'h000, exception_stack_pointer};
          `NPIU_OFF_PC: prdata <= {11'h000, program_stack_pointer};
          `NPIU_OFF_PSW: prdata <= {11'h000, saved_pc_r};
          `NPIU_OFF_BASE: prdata <= {11'h000, dispatch_table_base};
          `NPIU_OFF_CMD: prdata <= 32'h00000000;
          default: pslverr <= 1'b1;
        endcase
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule // npiu_top

// ### tb/npiu_core_model.sv
// Purpose: core-side model that counts the traps the unit hands over
// Assumes: trap_req_r is a one-cycle pulse per accepted pin edge
// Notes: a held level would be counted many times, which the bench would catch
`timescale 1ns/10ps
module npiu_core_model (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // from the unit
  input wire trap_req_r,
  // bookkeeping
  output int trap_cnt
);
  // each pulse is one trap taken
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      trap_cnt <= 0;
    else if (trap_req_r)
      trap_cnt <= trap_cnt + 1;
  end
endmodule // npiu_core_model

// ### tb/npiu_top_properties.sv
// Purpose: port-level checks for the interrupt unit
// Assumes: zero wait state apb, registered outputs
// Notes: bound to every npiu_top instance
`timescale 1ns/10ps
module npiu_props (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // trap and core side
  input wire trap_pin_n,
  input wire trap_req_r,
  input wire irq_req_r,
  input wire [5:0] irq_vec_r,
  input wire push_stb_r,
  input wire pop_stb_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (apb_setup |=> apb_access)
    else $error("no answer in access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_idle_no_ready: assert property (!psel |=> !pready)
    else $error("pready without a request");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside an answer");
  a_trap_one_pulse: assert property (trap_req_r |=> !trap_req_r)
    else $error("trap request longer than one cycle");
  // the pin must have been low before any trap shows
  a_trap_needs_low: assert property (trap_req_r |-> !$past(trap_pin_n, 2))
    else $error("trap without a low pin");
  // line 0 has no source, so the vector never names it
  a_vector_range: assert property (irq_req_r |-> irq_vec_r > 6'h10 && irq_vec_r <= 6'h2f)
    else $error("vector out of range");
  a_push_pop_apart: assert property (!(push_stb_r && pop_stb_r))
    else $error("push and pop together");
  cover property (apb_setup ##1 apb_access ##1 apb_setup);
endmodule // npiu_props

bind npiu_top npiu_props u_props (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .trap_pin_n(trap_pin_n),
  .trap_req_r(trap_req_r), .irq_req_r(irq_req_r), .irq_vec_r(irq_vec_r),
  .push_stb_r(push_stb_r), .pop_stb_r(pop_stb_r));

// ### tb/test_nmi_and_priority_interrupt_unit.sv
// Purpose: register-level tests of the interrupt unit
// Assumes: zero wait state apb, core model counts traps
// Notes: pin is held low well past the synchroniser delay
`timescale 1ns/10ps
`include "npiu_regs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module test_nmi_and_priority_interrupt_unit;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pin_n = 1, slv;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, pen = 0;
  logic pready, pslverr, irq, trap, push, pop;
  logic [4:0] tim = 0;
  logic en = 1;
  logic [3:0] vt = 0;
  logic [17:0] oth = 0;
  logic [5:0] vec;
  logic [20:0] sa, da;
  int fail_count = 0, checks = 0, traps;
  npiu_top DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trap_pin_n(pin_n),
    .timer0_tick(tim[4]), .timer1_input_a(tim[3]), .timer1_input_b(tim[2]),
    .timer2_input_a(tim[1]), .timer2_input_b(tim[0]), .versatile_timer_req(vt),
    .other_req(oth), .periph_en(pen), .irq_req_r(irq), .irq_vec_r(vec),
    .trap_req_r(trap), .push_stb_r(push), .pop_stb_r(pop), .stack_addr_r(sa),
    .dispatch_addr_r(da));
  npiu_core_model CORE (.ref_clk(ref_clk), .rst(rst), .trap_req_r(trap), .trap_cnt(traps));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
  task rc(input logic [11:0] a, input logic [31:0] e); apb(0, a, 0); `CHK(q, e) endtask
  task fall;
    @(posedge ref_clk) pin_n <= 0;
    repeat (10) @(posedge ref_clk);
    pin_n <= 1;
    repeat (10) @(posedge ref_clk);
  endtask
  task settle; repeat (8) @(posedge ref_clk); endtask
  task stop_test;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    rc(`NPIU_OFF_MASK_LO, 32'hffff);
    rc(`NPIU_OFF_MASK_HI, 32'hffff);
    rc(`NPIU_OFF_CTRL, 32'h2);
    fall;
    rc(`NPIU_OFF_STATUS, 32'h0);
    wr(`NPIU_OFF_CTRL, 32'h3);
    fall;
    rc(`NPIU_OFF_STATUS, 32'h1);
    rc(`NPIU_OFF_STATUS, 32'h0);
    rc(`NPIU_OFF_CTRL, 32'h2);
    fall;
    rc(`NPIU_OFF_STATUS, 32'h0);
    wr(`NPIU_OFF_CTRL, 32'h1);
    wr(`NPIU_OFF_CTRL, 32'h4);
    fall;
    fall;
    `CHK(traps, 3)
    rc(`NPIU_OFF_MONITOR, 32'h1);
    wr(`NPIU_OFF_MONITOR, 32'h0);
    rc(`NPIU_OFF_MONITOR, 32'h0);
    wr(`NPIU_OFF_CTRL, 32'h0);
    rc(`NPIU_OFF_CTRL, 32'h6);
    // stack pointer is set before any interrupt is taken
    wr(`NPIU_OFF_ESP, 32'h100);
    wr(`NPIU_OFF_BASE, 32'h1000);
    wr(`NPIU_OFF_CMD, 32'h1);
    @(negedge ref_clk);
    `CHK(push, 1'b1)
    `CHK(sa, 21'h0000fc)
    `CHK(da, 21'h001000)
    rc(`NPIU_OFF_ESP, 32'hfc);
    wr(`NPIU_OFF_CMD, 32'h2);
    @(negedge ref_clk);
    `CHK(pop, 1'b1)
    `CHK(sa, 21'h0000fc)
    rc(`NPIU_OFF_ESP, 32'h100);
    pen <= 32'hffff_fffe;
    tim <= 5'h10;
    oth <= 18'h20;
    wr(`NPIU_OFF_CORE, 32'h1);
    settle;
    `CHK(irq, 1'b0)
    wr(`NPIU_OFF_CMD, 32'h4);
    settle;
    rc(`NPIU_OFF_VECTOR, 32'h2f);
    `CHK(vec, 6'h2f)
    rc(`NPIU_OFF_DEBUG, 32'hbef);
    rc(`NPIU_OFF_LEVEL_HI, 32'h8000);
    wr(`NPIU_OFF_MASK_HI, 32'h7fff);
    settle;
    `CHK(vec, 6'h16)
    `CHK(irq, 1'b1)
    pen[6] <= 0;
    settle;
    `CHK(irq, 1'b0)
    en <= 0;
    pen[6] <= 1;
    settle;
    `CHK(irq, 1'b0)
    en <= 1;
    settle;
    `CHK(irq, 1'b1)
    wr(`NPIU_OFF_CMD, 32'h8);
    settle;
    `CHK(irq, 1'b0)
    rc(`NPIU_OFF_LEVEL_LO, 32'h40);
    apb(0, 12'h0fc, 0);
    `CHK(slv, 1'b1)
    stop_test;
  end
endmodule // test_nmi_and_priority_interrupt_unit
